// [ipc_far.sv]
// far-side model: external interrupt source and port pin loads
`timescale 1ns/100ps
`default_nettype none
module ipc_far (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        ext_fire,
    output logic             ext_int_n,
    input  wire logic [23:0] port_out,
    input  wire logic [23:0] port_oe,
    input  wire logic [23:0] port_far,
    output logic      [23:0] port_pin
);
    // ========================================
    // external pin: one fire gives a low pulse of four cycles
    logic [2:0] low_cnt_reg;
    // pulse longer than the synchroniser so the falling edge is seen
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt_reg <= 3'h0;
        end else if (ext_fire) begin
            low_cnt_reg <= 3'h4;
        end else if (low_cnt_reg != 3'h0) begin
            low_cnt_reg <= low_cnt_reg - 3'h1;
        end
    end
    assign ext_int_n = (low_cnt_reg == 3'h0);
    // ========================================
    // pin level: driven bits show the latch, the rest the load level
    assign port_pin = (port_oe & port_out) | (~port_oe & port_far);
endmodule
`default_nettype wire

// [ipc_pkg.sv]
// constants and types shared by the interrupt and port control block
package ipc_pkg;

    // ========================================
    // bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // ========================================
    // register offsets
    localparam logic [11:0] OFF_PORT_A     = 12'h000;
    localparam logic [11:0] OFF_PORT_B     = 12'h001;
    localparam logic [11:0] OFF_PORT_C     = 12'h002;
    localparam logic [11:0] OFF_PORT_D     = 12'h003;
    localparam logic [11:0] OFF_DIR_A      = 12'h004;
    localparam logic [11:0] OFF_DIR_B      = 12'h005;
    localparam logic [11:0] OFF_DIR_C      = 12'h006;
    localparam logic [11:0] OFF_TIMER_CTRL = 12'h008;
    localparam logic [11:0] OFF_MISC_CTRL  = 12'h00A;

    // ========================================
    // field positions and reset values
    localparam int          REQ_BIT      = 7;
    localparam int          AUX_MASK_BIT = 6;
    localparam int          AUX_PIN_BIT  = 6;
    localparam logic [7:0]  DIR_RESET    = 8'h00;
    localparam logic [7:0]  DIR_READ     = 8'hFF;
    localparam logic [7:0]  TCR_RESET    = 8'h00;
    localparam logic [7:0]  MISC_RESET   = 8'h40;
    localparam logic [7:0]  MISC_RW_MASK = 8'h40;
    localparam logic [7:0]  UNMAPPED_RD  = 8'h00;

    // ========================================
    // interrupt entry timing, in machine cycles (one mclk each)
    localparam int          SEQ_CYCLES   = 11;
    localparam logic [3:0]  SEQ_CNT_LOAD = 4'(SEQ_CYCLES - 2);
    localparam logic [3:0]  SEQ_CNT_ZERO = 4'h0;
    localparam logic [3:0]  SEQ_CNT_STEP = 4'h1;

    // ========================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STACK = 3'b010,
        ST_VEC   = 3'b100
    } ipc_seq_e;

    typedef enum logic [1:0] {
        VEC_NONE   = 2'h0,
        VEC_EXT    = 2'h1,
        VEC_SHARED = 2'h2,
        VEC_TRAP   = 2'h3
    } ipc_vec_e;

endpackage

// [ipc_top.sv]
// interrupt sequencing and parallel port control
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RQ1: four sources: pin, timer, aux pin, trap
// RQ2: finish instruction, stack, set mask, vector
// RQ3: entry sequence lasts eleven machine cycles
// RQ4: trap return restores stacked mask flag
// RQ5: hardware requests wait for instruction end
// RQ6: masked requests stay latched until unmasked
// RQ7: external pin beats timer when both pending
// RQ8: timer and aux share one vector
// RQ9: request flags cleared by writing zero only
// RQ10: pins synchronised, falling edge latches request
// RQ11: aux flag bit seven, mask bit six
// RQ12: aux mask set blocks aux interrupt
// RQ13: aux pin always readable on port d
// RQ14: timer/aux flags interrupt only when unmasked
// RQ15: trap taken regardless of mask flag
// RQ16: direction one is output, zero input
// RQ17: reset clears all direction registers
// RQ18: reset leaves output latches untouched
// RQ19: output bits read back the latch
// RQ20: input bits read the pin level
// RQ21: port write updates every latch bit
// RQ22: direction registers write-only, read all ones
// RQ23: external pin ranks above shared vector group
module ipc_top (
    input  wire logic                       mclk,
    input  wire logic                       arst_n,
    input  wire logic [ipc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ipc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [ipc_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                       ext_int_n,
    input  wire logic                       timer_req,
    input  wire logic                       instr_done,
    input  wire logic                       soft_trap_op,
    input  wire logic                       trap_return_op,
    input  wire logic                       stacked_mask,
    input  wire logic                       mask_load,
    input  wire logic                       mask_value,
    output logic                            ccr_mask,
    output logic                            cpu_hold,
    output logic                            svc_start,
    output ipc_pkg::ipc_vec_e               svc_vector,
    input  wire logic [ipc_pkg::DATA_W-1:0] pa_in,
    output logic      [ipc_pkg::DATA_W-1:0] pa_out,
    output logic      [ipc_pkg::DATA_W-1:0] pa_oe,
    input  wire logic [ipc_pkg::DATA_W-1:0] pb_in,
    output logic      [ipc_pkg::DATA_W-1:0] pb_out,
    output logic      [ipc_pkg::DATA_W-1:0] pb_oe,
    input  wire logic [ipc_pkg::DATA_W-1:0] pc_in,
    output logic      [ipc_pkg::DATA_W-1:0] pc_out,
    output logic      [ipc_pkg::DATA_W-1:0] pc_oe,
    input  wire logic [ipc_pkg::DATA_W-1:0] pd_in
);
    import ipc_pkg::*;

    // ========================================
    // helpers
    // output bits give the latch, input bits the pin
    function automatic logic [7:0] port_read(
        input logic [7:0] dir,
        input logic [7:0] latch,
        input logic [7:0] pin
    );
        port_read = (dir & latch) | (~dir & pin); // RQ19 RQ20
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // ========================================
    // pin synchronisers and falling edge detect
    logic [2:0] ext_sync_reg;
    logic [2:0] ext_sync_next;
    logic [2:0] aux_sync_reg;
    logic [2:0] aux_sync_next;
    logic       ext_fall;
    logic       aux_fall;

    // bit 0 feeds only bit 1; the edge is seen between bits 1 and 2
    always_comb begin
        ext_sync_next = {ext_sync_reg[1:0], ext_int_n}; // RQ10
        aux_sync_next = {aux_sync_reg[1:0], pd_in[AUX_PIN_BIT]}; // RQ10
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ext_sync_reg <= 3'h7;
            aux_sync_reg <= 3'h7;
        end else begin
            ext_sync_reg <= ext_sync_next;
            aux_sync_reg <= aux_sync_next;
        end
    end

    assign ext_fall = ext_sync_reg[2] & ~ext_sync_reg[1]; // RQ10
    assign aux_fall = aux_sync_reg[2] & ~aux_sync_reg[1]; // RQ10

    // ========================================
    // control registers and read path
    logic [7:0] dir_a_reg;
    logic [7:0] dir_a_next;
    logic [7:0] dir_b_reg;
    logic [7:0] dir_b_next;
    logic [7:0] dir_c_reg;
    logic [7:0] dir_c_next;
    logic [7:0] tcr_reg;
    logic [7:0] tcr_next;
    logic [7:0] misc_reg;
    logic [7:0] misc_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] lat_a_reg;
    logic [7:0] lat_b_reg;
    logic [7:0] lat_c_reg;
    logic       tcr_wr;
    logic       misc_wr;

    assign tcr_wr  = reg_wr & hit(reg_addr, OFF_TIMER_CTRL);
    assign misc_wr = reg_wr & hit(reg_addr, OFF_MISC_CTRL);

    always_comb begin
        dir_a_next = dir_a_reg;
        dir_b_next = dir_b_reg;
        dir_c_next = dir_c_reg;
        // whole-byte store only; no read-modify-write path exists
        if (reg_wr && hit(reg_addr, OFF_DIR_A)) dir_a_next = reg_wdata; // RQ22
        if (reg_wr && hit(reg_addr, OFF_DIR_B)) dir_b_next = reg_wdata; // RQ22
        if (reg_wr && hit(reg_addr, OFF_DIR_C)) dir_c_next = reg_wdata; // RQ22
        tcr_next = tcr_reg;
        if (tcr_wr) begin
            tcr_next[REQ_BIT-1:0] = reg_wdata[REQ_BIT-1:0];
            // writing one leaves the flag alone
            tcr_next[REQ_BIT] = tcr_reg[REQ_BIT] & reg_wdata[REQ_BIT]; // RQ9
        end
        if (timer_req) tcr_next[REQ_BIT] = 1'b1; // RQ1
        misc_next = misc_reg;
        if (misc_wr) begin
            misc_next = (misc_reg & ~MISC_RW_MASK) | (reg_wdata & MISC_RW_MASK); // RQ11
            misc_next[REQ_BIT] = misc_reg[REQ_BIT] & reg_wdata[REQ_BIT]; // RQ9
        end
        // set beats a clear in the same cycle
        if (aux_fall && !misc_reg[AUX_MASK_BIT]) misc_next[REQ_BIT] = 1'b1; // RQ12
        rdata_next = UNMAPPED_RD;
        if (reg_rd) begin
            case (reg_addr)
                OFF_PORT_A:     rdata_next = port_read(dir_a_reg, lat_a_reg, pa_in);
                OFF_PORT_B:     rdata_next = port_read(dir_b_reg, lat_b_reg, pb_in);
                OFF_PORT_C:     rdata_next = port_read(dir_c_reg, lat_c_reg, pc_in);
                OFF_PORT_D:     rdata_next = pd_in; // RQ13
                OFF_DIR_A:      rdata_next = DIR_READ; // RQ22
                OFF_DIR_B:      rdata_next = DIR_READ; // RQ22
                OFF_DIR_C:      rdata_next = DIR_READ; // RQ22
                OFF_TIMER_CTRL: rdata_next = tcr_reg; // RQ8
                OFF_MISC_CTRL:  rdata_next = misc_reg; // RQ8
                default:        rdata_next = UNMAPPED_RD;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dir_a_reg <= DIR_RESET; // RQ17
            dir_b_reg <= DIR_RESET; // RQ17
            dir_c_reg <= DIR_RESET; // RQ17
            tcr_reg   <= TCR_RESET;
            misc_reg  <= MISC_RESET;
            rdata_reg <= UNMAPPED_RD;
        end else begin
            dir_a_reg <= dir_a_next;
            dir_b_reg <= dir_b_next;
            dir_c_reg <= dir_c_next;
            tcr_reg   <= tcr_next;
            misc_reg  <= misc_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ========================================
    // output latches, deliberately outside reset
    logic [7:0] lat_a_next;
    logic [7:0] lat_b_next;
    logic [7:0] lat_c_next;

    always_comb begin
        lat_a_next = lat_a_reg;
        lat_b_next = lat_b_reg;
        lat_c_next = lat_c_reg;
        // every bit is written, whatever its direction
        if (reg_wr && hit(reg_addr, OFF_PORT_A)) lat_a_next = reg_wdata; // RQ21
        if (reg_wr && hit(reg_addr, OFF_PORT_B)) lat_b_next = reg_wdata; // RQ21
        if (reg_wr && hit(reg_addr, OFF_PORT_C)) lat_c_next = reg_wdata; // RQ21
    end

    // unknown until software writes them first
    always_ff @(posedge mclk) begin
        lat_a_reg <= lat_a_next; // RQ18
        lat_b_reg <= lat_b_next; // RQ18
        lat_c_reg <= lat_c_next; // RQ18
    end

    assign pa_out = lat_a_reg;
    assign pb_out = lat_b_reg;
    assign pc_out = lat_c_reg;
    assign pa_oe  = dir_a_reg; // RQ16
    assign pb_oe  = dir_b_reg; // RQ16
    assign pc_oe  = dir_c_reg; // RQ16

    // ========================================
    // interrupt entry sequencer
    ipc_seq_e   state_reg;
    ipc_seq_e   state_next;
    ipc_vec_e   vec_reg;
    ipc_vec_e   vec_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       mask_reg;
    logic       mask_next;
    logic       ext_pend_reg;
    logic       ext_pend_next;
    logic       shared_req;
    logic       take_ext;

    assign shared_req = tcr_reg[REQ_BIT] | misc_reg[REQ_BIT]; // RQ8 RQ14
    assign take_ext   = (state_reg == ST_IDLE) && instr_done && !soft_trap_op
                        && ext_pend_reg && !mask_reg;

    always_comb begin
        state_next = state_reg;
        vec_next   = vec_reg;
        cnt_next   = cnt_reg;
        mask_next  = mask_reg;
        // held until serviced, even while masked
        ext_pend_next = (ext_pend_reg & ~take_ext) | ext_fall; // RQ6 RQ10
        case (state_reg)
            ST_IDLE: begin
                if (trap_return_op) begin
                    mask_next = stacked_mask; // RQ4
                end else if (mask_load) begin
                    mask_next = mask_value;
                end
                // only an instruction boundary can start entry
                if (instr_done) begin // RQ5
                    if (soft_trap_op) begin
                        vec_next = VEC_TRAP; // RQ15
                    end else if (take_ext) begin
                        vec_next = VEC_EXT; // RQ7 RQ23
                    end else if (shared_req && !mask_reg) begin
                        vec_next = VEC_SHARED; // RQ8 RQ14
                    end else begin
                        vec_next = VEC_NONE; // RQ6
                    end
                    if (soft_trap_op || take_ext || (shared_req && !mask_reg)) begin
                        state_next = ST_STACK; // RQ2
                        cnt_next   = SEQ_CNT_LOAD; // RQ3
                        mask_next  = 1'b1; // RQ2
                    end
                end
            end
            ST_STACK: begin
                cnt_next = cnt_reg - SEQ_CNT_STEP;
                if (cnt_reg == SEQ_CNT_ZERO) state_next = ST_VEC; // RQ3
            end
            ST_VEC: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= ST_IDLE;
            vec_reg      <= VEC_NONE;
            cnt_reg      <= SEQ_CNT_ZERO;
            mask_reg     <= 1'b1;
            ext_pend_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            vec_reg      <= vec_next;
            cnt_reg      <= cnt_next;
            mask_reg     <= mask_next;
            ext_pend_reg <= ext_pend_next;
        end
    end

    // cpu stays suspended for the whole stacking window
    assign cpu_hold   = (state_reg != ST_IDLE); // RQ2
    assign svc_start  = (state_reg == ST_VEC); // RQ2
    assign svc_vector = vec_reg;
    assign ccr_mask   = mask_reg;

    // ========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_SEQ_LEN: assert property ( // RQ3
        $rose(cpu_hold) |-> cpu_hold[*8] ##1 cpu_hold[*3] ##1 !cpu_hold
    ) else $error("entry sequence length wrong");

    AST_MASK_SET: assert property ( // RQ2
        $rose(cpu_hold) |-> ccr_mask ##10 (svc_start && ccr_mask)
    ) else $error("mask not set or vector late");

    AST_NO_ABORT: assert property ( // RQ5
        $rose(cpu_hold) |-> $past(instr_done)
    ) else $error("entry without instruction end");

    AST_EXT_FIRST: assert property ( // RQ7
        (take_ext && shared_req) |=> (vec_reg == VEC_EXT)
    ) else $error("external pin not served first");

    AST_MASKED_WAIT: assert property ( // RQ14
        (state_reg == ST_IDLE && instr_done && !soft_trap_op && mask_reg)
        |=> !cpu_hold
    ) else $error("masked request taken");

    AST_TRAP: assert property ( // RQ15
        (state_reg == ST_IDLE && instr_done && soft_trap_op)
        |=> (cpu_hold && vec_reg == VEC_TRAP)
    ) else $error("trap not taken");

    AST_W1_NOEFFECT: assert property ( // RQ9
        (tcr_wr && reg_wdata[REQ_BIT] && !tcr_reg[REQ_BIT] && !timer_req)
        |=> !tcr_reg[REQ_BIT]
    ) else $error("writing one set timer flag");

    AST_DIR_WO: assert property ( // RQ22
        (reg_rd && reg_addr == OFF_DIR_B) |=> (reg_rdata == DIR_READ)
    ) else $error("direction register read not all ones");

    AST_PORT_READ: assert property ( // RQ19
        (reg_rd && reg_addr == OFF_PORT_A)
        |=> (reg_rdata == ((dir_a_reg & lat_a_reg) | (~dir_a_reg & $past(pa_in))))
    ) else $error("port read mismatch");

    AST_AUX_MASKED: assert property ( // RQ12
        (aux_fall && misc_reg[AUX_MASK_BIT] && !misc_reg[REQ_BIT])
        |=> !misc_reg[REQ_BIT]
    ) else $error("masked aux edge set flag");

    AST_EDGE: assert property ( // RQ10
        $fell(ext_int_n) |-> ##3 ext_pend_reg
    ) else $error("falling edge not latched");

endmodule

`default_nettype wire

// [ipc_top_bench.sv]
// self-checking bench for the interrupt and port control block
`timescale 1ns/100ps
`default_nettype none
module ipc_top_bench;
    import ipc_pkg::*;
    // ========================================
    // signals
    logic        mclk = 1'b0;
    logic        arst_n, reg_wr, reg_rd, ext_fire, ext_int_n, timer_req, instr_done;
    logic        soft_trap_op, trap_return_op, stacked_mask, mask_load, mask_value;
    logic        ccr_mask, cpu_hold, svc_start;
    ipc_vec_e    svc_vector;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, pd_in;
    logic [23:0] out_all, oe_all, pin_all, far_all;
    int          miscompares = 0;
    int          n_compared  = 0;
    int          cyc         = 0;
    int          n;

    always #2 mclk = ~mclk;

    ipc_top ipc_top_inst (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_int_n(ext_int_n),
        .timer_req(timer_req), .instr_done(instr_done), .soft_trap_op(soft_trap_op),
        .trap_return_op(trap_return_op), .stacked_mask(stacked_mask), .mask_load(mask_load),
        .mask_value(mask_value), .ccr_mask(ccr_mask), .cpu_hold(cpu_hold), .svc_start(svc_start),
        .svc_vector(svc_vector), .pa_in(pin_all[7:0]), .pa_out(out_all[7:0]), .pa_oe(oe_all[7:0]),
        .pb_in(pin_all[15:8]), .pb_out(out_all[15:8]), .pb_oe(oe_all[15:8]),
        .pc_in(pin_all[23:16]), .pc_out(out_all[23:16]), .pc_oe(oe_all[23:16]), .pd_in(pd_in));

    ipc_far ipc_far_inst (.mclk(mclk), .arst_n(arst_n), .ext_fire(ext_fire), .ext_int_n(ext_int_n),
        .port_out(out_all), .port_oe(oe_all), .port_far(far_all), .port_pin(pin_all));

    // ========================================
    // checking and closing
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ========================================
    // register bus and cpu side tasks
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic unmask();
        @(posedge mclk);
        mask_load  <= 1'b1;
        mask_value <= 1'b0;
        @(posedge mclk);
        mask_load  <= 1'b0;
    endtask

    task automatic take(input ipc_vec_e v, input logic trap);
        @(posedge mclk);
        instr_done   <= 1'b1;
        soft_trap_op <= trap;
        @(posedge mclk);
        instr_done   <= 1'b0;
        soft_trap_op <= 1'b0;
        #1 chk({7'h0, cpu_hold}, 8'h01);
        chk({6'h0, svc_vector}, {6'h0, v});
        chk({7'h0, ccr_mask}, 8'h01);
        n = 1;
        while (svc_start !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1 n++;
        end
        chk(8'(n), 8'h0B);
        @(posedge mclk);
        #1 chk({7'h0, cpu_hold}, 8'h00);
    endtask

    task automatic no_entry();
        @(posedge mclk);
        instr_done <= 1'b1;
        @(posedge mclk);
        instr_done <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk({7'h0, cpu_hold}, 8'h00);
    endtask

    // ========================================
    // main sequence
    initial begin
        {arst_n, reg_wr, reg_rd, ext_fire, timer_req, instr_done} = '0;
        {soft_trap_op, trap_return_op, stacked_mask, mask_load, mask_value} = '0;
        reg_addr  = 12'h000;
        reg_wdata = 8'h00;
        pd_in     = 8'hFF;
        far_all   = 24'hC33CA5;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        #1 chk(oe_all[7:0] | oe_all[15:8] | oe_all[23:16], 8'h00);
        rd(OFF_MISC_CTRL, MISC_RESET);
        rd(12'h00C, UNMAPPED_RD);
        for (int p = 0; p < 3; p++) begin
            rd(OFF_DIR_A + 12'(p), DIR_READ);
            wr(OFF_PORT_A + 12'(p), 8'h5A);
            #1 chk(out_all[p*8+:8], 8'h5A);
            wr(OFF_DIR_A + 12'(p), 8'h0F);
            #1 chk(oe_all[p*8+:8], 8'h0F);
            rd(OFF_PORT_A + 12'(p), (far_all[p*8+:8] & 8'hF0) | 8'h0A);
        end
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        #1 chk(oe_all[7:0] | oe_all[15:8] | oe_all[23:16], 8'h00);
        chk(out_all[7:0] & out_all[15:8] & out_all[23:16], 8'h5A);
        // aux pin falls while its mask is set: readable, no flag
        @(posedge mclk);
        pd_in <= 8'h96;
        repeat (5) @(posedge mclk);
        rd(OFF_PORT_D, 8'h96);
        rd(OFF_MISC_CTRL, 8'h40);
        // external request held while the mask flag is set
        @(posedge mclk);
        ext_fire <= 1'b1;
        @(posedge mclk);
        ext_fire <= 1'b0;
        repeat (6) @(posedge mclk);
        no_entry();
        unmask();
        take(VEC_EXT, 1'b0);
        // external and timer pending together
        @(posedge mclk);
        ext_fire  <= 1'b1;
        timer_req <= 1'b1;
        @(posedge mclk);
        ext_fire  <= 1'b0;
        timer_req <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(OFF_TIMER_CTRL, 8'h80);
        no_entry();
        unmask();
        take(VEC_EXT, 1'b0);
        unmask();
        take(VEC_SHARED, 1'b0);
        wr(OFF_TIMER_CTRL, 8'hFF);
        rd(OFF_TIMER_CTRL, 8'hFF);
        wr(OFF_TIMER_CTRL, 8'h00);
        rd(OFF_TIMER_CTRL, 8'h00);
        // a one written to a clear flag must not set it
        wr(OFF_TIMER_CTRL, 8'h80);
        rd(OFF_TIMER_CTRL, 8'h00);
        // aux pin unmasked: falling edge latches its flag
        wr(OFF_MISC_CTRL, 8'h00);
        pd_in <= 8'hFF;
        repeat (4) @(posedge mclk);
        pd_in <= 8'hBF;
        repeat (5) @(posedge mclk);
        rd(OFF_MISC_CTRL, 8'h80);
        unmask();
        take(VEC_SHARED, 1'b0);
        wr(OFF_MISC_CTRL, 8'h80);
        rd(OFF_MISC_CTRL, 8'h80);
        wr(OFF_MISC_CTRL, 8'h40);
        rd(OFF_MISC_CTRL, 8'h40);
        wr(OFF_MISC_CTRL, 8'hC0);
        rd(OFF_MISC_CTRL, 8'h40);
        // trap runs with the mask flag set, return restores it
        take(VEC_TRAP, 1'b1);
        @(posedge mclk);
        trap_return_op <= 1'b1;
        stacked_mask   <= 1'b0;
        @(posedge mclk);
        trap_return_op <= 1'b0;
        #1 chk({7'h0, ccr_mask}, 8'h00);
        no_entry();
        print_verdict();
    end
endmodule
`default_nettype wire
